//--- rtl/wsc_top.sv
// Added by the designer: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
// Overview of operation
// - Only on-chip DMA engine bus cycles are stretched with wait states.
// - Waits come from the wait-request pin and from per-area counts.
// - Each of three areas has its own count from zero to seven.
// - Wait-request is active high; waits continue while it stays high.
// - Wait states sit between the second and third bus states.
// - Lower boundary holds address bits 23..16 of the middle area start.
// - Upper boundary holds address bits 23..16 of the high area start.
// - Boundary low sixteen bits are zero, giving 64-kilobyte steps.
// - A zero boundary sits at the top, so its upper area vanishes.
// - Upper zero with lower nonzero: middle area runs to the top.
// - Low area register bits 2..0 give the binary wait count.
// - Middle area register bits 2..0 give its binary wait count.
// - High area register bits 2..0 give its binary wait count.
// - Wait register bits 7..3 read zero; software writes zero.
// - Reset sets the three area wait count fields to seven; the status count field resets to zero.
// - Lower boundary resets to zero and is read-write.
// - Wait states go on while wait-request is sampled high, unbounded.
// - With both sources active, the larger wait count applies.
// - Stop mode halts the sequencer, keeping registers; reset clears boundaries.
module wsc_top
    import wsc_pkg::*;
(
    // Clock and reset.
    input wire logic CLK,
    input wire logic RST_B,
    // AHB-Lite slave.
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // DMA engine cycle request.
    input wire logic DMA_CYCLE_START,
    input wire logic [23:0] DMA_ADDR,
    input wire logic SYSTEM_STOP,
    // Wait-request pin.
    input wire logic WAIT_REQ,
    // Bus cycle state and area.
    output logic [4:0] BUS_STATE,
    output logic [1:0] BUS_AREA
);

    wsc_regs_t q;
    wsc_regs_t d;
    wsc_area_if ar ();

    logic take;
    wsc_reg_t ap_reg;
    logic [2:0] cnt_dec;
    logic more_wait;

    function automatic wsc_reg_t reg_decode(input logic [31:0] a);
        if (a[31:12] != 20'h00000) begin
            reg_decode = WSC_REG_NONE;
        end else if (a[11:0] == WSC_OFS_LOWER_BND) begin
            reg_decode = WSC_REG_LOWER_BND;
        end else if (a[11:0] == WSC_OFS_UPPER_BND) begin
            reg_decode = WSC_REG_UPPER_BND;
        end else if (a[11:0] == WSC_OFS_LOW_WAIT) begin
            reg_decode = WSC_REG_LOW_WAIT;
        end else if (a[11:0] == WSC_OFS_MID_WAIT) begin
            reg_decode = WSC_REG_MID_WAIT;
        end else if (a[11:0] == WSC_OFS_HIGH_WAIT) begin
            reg_decode = WSC_REG_HIGH_WAIT;
        end else if (a[11:0] == WSC_OFS_STATUS) begin
            reg_decode = WSC_REG_STATUS;
        end else begin
            reg_decode = WSC_REG_NONE;
        end
    endfunction

    // Read value is built from the next state so a read right after a write sees the new value.
    function automatic logic [31:0] reg_read(input wsc_regs_t s, input wsc_reg_t r);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (r)
            WSC_REG_LOWER_BND: v[7:0] = s.lower_bnd;
            WSC_REG_UPPER_BND: v[7:0] = s.upper_bnd;
            WSC_REG_LOW_WAIT: v[2:0] = s.wait_low;
            WSC_REG_MID_WAIT: v[2:0] = s.wait_mid;
            WSC_REG_HIGH_WAIT: v[2:0] = s.wait_high;
            WSC_REG_STATUS: begin
                v[WSC_STAT_AREA_LSB +: 2] = s.area;
                v[WSC_STAT_STATE_LSB +: 5] = s.state;
                v[WSC_STAT_WAIT_BIT] = s.wait_flt;
                v[WSC_STAT_CNT_LSB +: 3] = s.cnt;
            end
            default: v = 32'h0000_0000;
        endcase
        reg_read = v;
    endfunction

    assign ar.addr_hi = DMA_ADDR[WSC_ADDR_W-1:WSC_BND_LSB];
    assign ar.lower_bnd = q.lower_bnd;
    assign ar.upper_bnd = q.upper_bnd;
    assign ar.wait_low = q.wait_low;
    assign ar.wait_mid = q.wait_mid;
    assign ar.wait_high = q.wait_high;

    wsc_area_sel u_area_sel (
        .ar(ar)
    );

    always_comb begin
        d = q;
        take = HSEL && HTRANS[1] && HREADY;
        ap_reg = reg_decode(HADDR);
        cnt_dec = (q.cnt == WSC_WAIT_ZERO) ? WSC_WAIT_ZERO : q.cnt - 3'h1;
        more_wait = 1'b0;

        // Wait pin: a change counts once the second and third stages agree.
        // hardware wait source
        d.wait_sync = {q.wait_sync[1:0], WAIT_REQ};
        if (q.wait_sync[1] == q.wait_sync[2]) begin
            d.wait_flt = q.wait_sync[2];
        end

        // Register writes land in the data phase.
        if (q.dp_vld && q.dp_wr) begin
            case (q.dp_reg)
                WSC_REG_LOWER_BND: d.lower_bnd = HWDATA[7:0];
                WSC_REG_UPPER_BND: d.upper_bnd = HWDATA[7:0];
                WSC_REG_LOW_WAIT: d.wait_low = HWDATA[2:0];
                WSC_REG_MID_WAIT: d.wait_mid = HWDATA[2:0];
                WSC_REG_HIGH_WAIT: d.wait_high = HWDATA[2:0];
                default: d.lower_bnd = q.lower_bnd;
            endcase
        end

        if (!SYSTEM_STOP) begin
            case (q.state)
                WSC_ST_IDLE: begin
                    if (DMA_CYCLE_START) begin
                        d.state = WSC_ST_T1;
                        d.area = ar.area;
                        d.cnt = ar.wait_cnt;
                    end
                end
                WSC_ST_T1: begin
                    d.state = WSC_ST_T2;
                end
                WSC_ST_T2: begin
                    if (q.cnt != WSC_WAIT_ZERO || q.wait_flt) begin
                        d.state = WSC_ST_TW;
                    end else begin
                        d.state = WSC_ST_T3;
                    end
                end
                WSC_ST_TW: begin
                    d.cnt = cnt_dec;
                    more_wait = (cnt_dec != WSC_WAIT_ZERO) || q.wait_flt;
                    if (more_wait) begin
                        d.state = WSC_ST_TW;
                    end else begin
                        d.state = WSC_ST_T3;
                    end
                end
                WSC_ST_T3: begin
                    d.state = WSC_ST_IDLE;
                end
                default: begin
                    d.state = WSC_ST_IDLE;
                end
            endcase
        end

        // Address phase capture; the slave always answers without wait and OKAY.
        d.dp_vld = take;
        d.dp_wr = take && HWRITE;
        d.dp_reg = take ? ap_reg : WSC_REG_NONE;
        if (take && !HWRITE) begin
            d.rdata = reg_read(d, ap_reg);
        end
        d.ready = 1'b1;
        d.resp = 1'b0;
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            q <= WSC_REGS_RST;
        end else begin
            q <= d;
        end
    end

    assign HRDATA = q.rdata;
    assign HREADYOUT = q.ready;
    assign HRESP = q.resp;
    assign BUS_STATE = q.state;
    assign BUS_AREA = q.area;

    // Checks on the sequencer and register file.
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);

    sequence s_t2_go;
        q.state == WSC_ST_T2 && !SYSTEM_STOP;
    endsequence

    sequence s_t3_then_idle;
        q.state == WSC_ST_T3 ##1 q.state == WSC_ST_IDLE;
    endsequence

    sequence s_start;
        q.state == WSC_ST_IDLE && DMA_CYCLE_START && !SYSTEM_STOP;
    endsequence

    property p_t1_to_t2;
        q.state == WSC_ST_T1 && !SYSTEM_STOP |=> q.state == WSC_ST_T2;
    endproperty
    a_t1_to_t2: assert property (p_t1_to_t2) else $error("T1 did not advance to T2");

    property p_no_wait;
        s_t2_go and (q.cnt == WSC_WAIT_ZERO && !q.wait_flt) |=> s_t3_then_idle or SYSTEM_STOP;
    endproperty
    a_no_wait: assert property (p_no_wait) else $error("Zero-wait cycle did not finish through T3");

    property p_pin_hold;
        (q.state == WSC_ST_T2 || q.state == WSC_ST_TW) && !SYSTEM_STOP && q.wait_flt |=> q.state == WSC_ST_TW;
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("Wait pin high but no wait state");

    property p_cnt_dec;
        q.state == WSC_ST_TW && !SYSTEM_STOP && q.cnt != WSC_WAIT_ZERO |=> q.cnt == $past(q.cnt) - 3'h1;
    endproperty
    a_cnt_dec: assert property (p_cnt_dec) else $error("Wait count did not decrement");

    property p_reg_wait_hold;
        q.state == WSC_ST_TW && !SYSTEM_STOP && q.cnt > 3'h1 |=> q.state == WSC_ST_TW;
    endproperty
    a_reg_wait_hold: assert property (p_reg_wait_hold) else $error("Register wait ended early");

    property p_stop_freeze;
        SYSTEM_STOP && q.state != WSC_ST_IDLE |=> q.state == $past(q.state) && q.cnt == $past(q.cnt);
    endproperty
    a_stop_freeze: assert property (p_stop_freeze) else $error("Sequencer moved in stop mode");

    // The area is latched at cycle start, so the boundary is judged at that edge only.
    property p_high_needs_bnd;
        s_start and (q.upper_bnd == WSC_BND_RST) |=> q.area != WSC_AREA_HIGH;
    endproperty
    a_high_needs_bnd: assert property (p_high_needs_bnd) else $error("High area with zero upper boundary");

    property p_latch;
        s_start |=> q.state == WSC_ST_T1 && q.cnt == $past(ar.wait_cnt);
    endproperty
    a_latch: assert property (p_latch) else $error("Area count not latched at cycle start");

    property p_lb_write;
        q.dp_vld && q.dp_wr && q.dp_reg == WSC_REG_LOWER_BND |=> q.lower_bnd == $past(HWDATA[7:0]);
    endproperty
    a_lb_write: assert property (p_lb_write) else $error("Lower boundary write lost");

    property p_reserved_zero;
        q.dp_vld && !q.dp_wr && (q.dp_reg == WSC_REG_LOW_WAIT || q.dp_reg == WSC_REG_MID_WAIT
            || q.dp_reg == WSC_REG_HIGH_WAIT) |-> HRDATA[31:3] == 29'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("Wait register upper bits not zero");

    property p_t2_exit;
        q.state == WSC_ST_T2 && !SYSTEM_STOP |=> q.state == WSC_ST_TW || q.state == WSC_ST_T3;
    endproperty
    a_t2_exit: assert property (p_t2_exit) else $error("T2 did not lead to a wait or T3");

    property p_t3_idle;
        q.state == WSC_ST_T3 && !SYSTEM_STOP |=> q.state == WSC_ST_IDLE;
    endproperty
    a_t3_idle: assert property (p_t3_idle) else $error("T3 did not end the cycle");

    property p_idle_hold;
        q.state == WSC_ST_IDLE && !DMA_CYCLE_START |=> q.state == WSC_ST_IDLE;
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("Bus cycle began without a DMA request");

    // Neither source asks for more, so the wait must end here.
    property p_wait_end;
        q.state == WSC_ST_TW && !SYSTEM_STOP && q.cnt <= 3'h1 && !q.wait_flt |=> q.state == WSC_ST_T3;
    endproperty
    a_wait_end: assert property (p_wait_end) else $error("Wait state kept with no source asking");

    property p_area_high;
        s_start and (q.upper_bnd != WSC_BND_RST && ar.addr_hi >= q.upper_bnd) |=> q.area == WSC_AREA_HIGH;
    endproperty
    a_area_high: assert property (p_area_high) else $error("Address at or above upper boundary not high");

    // A zero upper boundary leaves the middle area running to the top of the space.
    property p_area_mid;
        s_start and (q.lower_bnd != WSC_BND_RST && ar.addr_hi >= q.lower_bnd
            && (q.upper_bnd == WSC_BND_RST || ar.addr_hi < q.upper_bnd)) |=> q.area == WSC_AREA_MID;
    endproperty
    a_area_mid: assert property (p_area_mid) else $error("Middle area address not classed middle");

    property p_area_low;
        s_start and ((q.lower_bnd == WSC_BND_RST || ar.addr_hi < q.lower_bnd)
            && (q.upper_bnd == WSC_BND_RST || ar.addr_hi < q.upper_bnd)) |=> q.area == WSC_AREA_LOW;
    endproperty
    a_area_low: assert property (p_area_low) else $error("Low area address not classed low");

    property p_wait_wr;
        q.dp_vld && q.dp_wr && q.dp_reg == WSC_REG_LOW_WAIT |=> q.wait_low == $past(HWDATA[2:0]);
    endproperty
    a_wait_wr: assert property (p_wait_wr) else $error("Low area wait count write lost");

    property p_ub_write;
        q.dp_vld && q.dp_wr && q.dp_reg == WSC_REG_UPPER_BND |=> q.upper_bnd == $past(HWDATA[7:0]);
    endproperty
    a_ub_write: assert property (p_ub_write) else $error("Upper boundary write lost");

    // Read data comes from the next state, so a write landing in the same cycle is already seen.
    property p_rd_lower;
        q.dp_vld && !q.dp_wr && q.dp_reg == WSC_REG_LOWER_BND |-> HRDATA == {24'h000000, q.lower_bnd};
    endproperty
    a_rd_lower: assert property (p_rd_lower) else $error("Lower boundary read data wrong");

    property p_rd_mid;
        q.dp_vld && !q.dp_wr && q.dp_reg == WSC_REG_MID_WAIT |-> HRDATA == {29'h00000000, q.wait_mid};
    endproperty
    a_rd_mid: assert property (p_rd_mid) else $error("Middle area wait count read data wrong");

endmodule

//--- include/wsc_pkg.sv
package wsc_pkg;

    // Register byte offsets on the AHB-Lite slave.
    localparam logic [11:0] WSC_OFS_LOWER_BND = 12'h000;
    localparam logic [11:0] WSC_OFS_UPPER_BND = 12'h004;
    localparam logic [11:0] WSC_OFS_LOW_WAIT = 12'h008;
    localparam logic [11:0] WSC_OFS_MID_WAIT = 12'h00c;
    localparam logic [11:0] WSC_OFS_HIGH_WAIT = 12'h010;
    localparam logic [11:0] WSC_OFS_STATUS = 12'h014;

    // Field layout.
    localparam int WSC_BND_W = 8;
    localparam int WSC_WAIT_W = 3;
    localparam int WSC_ADDR_W = 24;
    localparam int WSC_BND_LSB = 16;
    localparam int WSC_STAT_AREA_LSB = 0;
    localparam int WSC_STAT_STATE_LSB = 2;
    localparam int WSC_STAT_WAIT_BIT = 7;
    localparam int WSC_STAT_CNT_LSB = 8;

    // Reset values.
    localparam logic [7:0] WSC_BND_RST = 8'h00;
    localparam logic [2:0] WSC_WAIT_RST = 3'h7;
    localparam logic [2:0] WSC_WAIT_ZERO = 3'h0;

    typedef enum logic [1:0] {
        WSC_AREA_LOW = 2'h0,
        WSC_AREA_MID = 2'h1,
        WSC_AREA_HIGH = 2'h2
    } wsc_area_t;

    typedef enum logic [4:0] {
        WSC_ST_IDLE = 5'h01,
        WSC_ST_T1 = 5'h02,
        WSC_ST_T2 = 5'h04,
        WSC_ST_TW = 5'h08,
        WSC_ST_T3 = 5'h10
    } wsc_state_t;

    typedef enum logic [2:0] {
        WSC_REG_LOWER_BND = 3'h0,
        WSC_REG_UPPER_BND = 3'h1,
        WSC_REG_LOW_WAIT = 3'h2,
        WSC_REG_MID_WAIT = 3'h3,
        WSC_REG_HIGH_WAIT = 3'h4,
        WSC_REG_STATUS = 3'h5,
        WSC_REG_NONE = 3'h7
    } wsc_reg_t;

    typedef struct packed {
        wsc_state_t state;
        wsc_area_t area;
        logic [2:0] cnt;
        logic [7:0] lower_bnd;
        logic [7:0] upper_bnd;
        logic [2:0] wait_low;
        logic [2:0] wait_mid;
        logic [2:0] wait_high;
        logic [2:0] wait_sync;
        logic wait_flt;
        logic dp_vld;
        logic dp_wr;
        wsc_reg_t dp_reg;
        logic [31:0] rdata;
        logic ready;
        logic resp;
    } wsc_regs_t;

    localparam wsc_regs_t WSC_REGS_RST = '{
        state: WSC_ST_IDLE,
        area: WSC_AREA_LOW,
        cnt: 3'h0,
        lower_bnd: WSC_BND_RST,
        upper_bnd: WSC_BND_RST,
        wait_low: WSC_WAIT_RST,
        wait_mid: WSC_WAIT_RST,
        wait_high: WSC_WAIT_RST,
        wait_sync: 3'h0,
        wait_flt: 1'b0,
        dp_vld: 1'b0,
        dp_wr: 1'b0,
        dp_reg: WSC_REG_NONE,
        rdata: 32'h0000_0000,
        ready: 1'b1,
        resp: 1'b0
    };

endpackage

//--- include/wsc_area_if.sv
`timescale 1ns/1ps
interface wsc_area_if;
    import wsc_pkg::*;
    logic [7:0] addr_hi;
    logic [7:0] lower_bnd;
    logic [7:0] upper_bnd;
    logic [2:0] wait_low;
    logic [2:0] wait_mid;
    logic [2:0] wait_high;
    wsc_area_t area;
    logic [2:0] wait_cnt;
    modport ctl (output addr_hi, lower_bnd, upper_bnd, wait_low, wait_mid, wait_high, input area, wait_cnt);
    modport sel (input addr_hi, lower_bnd, upper_bnd, wait_low, wait_mid, wait_high, output area, wait_cnt);
endinterface

//--- rtl/wsc_area_sel.sv
`timescale 1ns/1ps
module wsc_area_sel
    import wsc_pkg::*;
(
    // Area lookup carrier.
    wsc_area_if.sel ar
);

    logic high_hit;
    logic mid_hit;

    // A zero boundary sits at the top of the space, so its upper area never matches.
    always_comb begin
        high_hit = (ar.upper_bnd != WSC_BND_RST) && (ar.addr_hi >= ar.upper_bnd);
        mid_hit = (ar.lower_bnd != WSC_BND_RST) && (ar.addr_hi >= ar.lower_bnd);
        if (high_hit) begin
            ar.area = WSC_AREA_HIGH;
            ar.wait_cnt = ar.wait_high;
        end else if (mid_hit) begin
            ar.area = WSC_AREA_MID;
            ar.wait_cnt = ar.wait_mid;
        end else begin
            ar.area = WSC_AREA_LOW;
            ar.wait_cnt = ar.wait_low;
        end
    end

endmodule

//--- dv/wsc_wait_model.sv
`timescale 1ns/1ps
module wsc_wait_model
    import wsc_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Observed bus cycle and requested extra waits.
    input wire logic [4:0] bus_state,
    input wire logic [3:0] hold,
    // Wait-request pin.
    output logic wait_req
);
    logic [3:0] cnt_q;

    // The pin is raised while idle so the device's synchroniser lag is covered before T2.
    // active-high wait hold
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 4'h0;
        end else if (bus_state == WSC_ST_IDLE) begin
            cnt_q <= hold;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end

    assign wait_req = (cnt_q != 4'h0);
endmodule

//--- dv/dma_wait_state_controller_test.sv
`timescale 1ns/1ps
`define CHK(a, e) chk_v(32'(a), 32'(e))
module dma_wait_state_controller_test;
    import wsc_pkg::*;
    logic CLK = 1'b0;
    logic RST_B = 1'b0;
    logic HSEL = 1'b0;
    logic [31:0] HADDR = 32'h0;
    logic [1:0] HTRANS = 2'h0;
    logic HWRITE = 1'b0;
    logic [31:0] HWDATA = 32'h0;
    logic [31:0] HRDATA;
    logic HREADYOUT;
    logic HRESP;
    logic DMA_CYCLE_START = 1'b0;
    logic [23:0] DMA_ADDR = 24'h0;
    logic SYSTEM_STOP = 1'b0;
    logic WAIT_REQ;
    logic [4:0] BUS_STATE;
    logic [1:0] BUS_AREA;
    logic [3:0] hold = 4'h0;
    logic [31:0] rd;
    int error_cnt = 0;
    int checks = 0;
    int last_w;

    wsc_top uut (.CLK(CLK), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
        .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
        .HRESP(HRESP), .DMA_CYCLE_START(DMA_CYCLE_START), .DMA_ADDR(DMA_ADDR), .SYSTEM_STOP(SYSTEM_STOP),
        .WAIT_REQ(WAIT_REQ), .BUS_STATE(BUS_STATE), .BUS_AREA(BUS_AREA));

    wsc_wait_model wm (.clk(CLK), .rst_b(RST_B), .bus_state(BUS_STATE), .hold(hold), .wait_req(WAIT_REQ));

    initial begin
        forever #2 CLK = ~CLK;
    end

    function automatic void chk_v(logic [31:0] a, logic [31:0] e);
        checks++;
        if (a !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e);
        end
    endfunction

    task automatic test_done();
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic ahb(logic wr, logic [11:0] a, logic [31:0] d);
        @(posedge CLK);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= {20'h0, a};
        HWRITE <= wr;
        @(posedge CLK);
        while (HREADYOUT !== 1'b1) @(posedge CLK);
        HTRANS <= 2'h0;
        HSEL <= 1'b0;
        HWDATA <= d;
        @(posedge CLK);
        while (HREADYOUT !== 1'b1) @(posedge CLK);
        rd = HRDATA;
        `CHK(HRESP, 1'b0);
    endtask

    task automatic rchk(logic [11:0] a, logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        `CHK(rd, e);
    endtask

    // Runs one DMA cycle; n < 0 skips the wait-count compare.
    task automatic dma(logic [23:0] a, wsc_area_t ar, int n, logic stp);
        last_w = 0;
        @(posedge CLK);
        DMA_CYCLE_START <= 1'b1;
        DMA_ADDR <= a;
        @(posedge CLK);
        DMA_CYCLE_START <= 1'b0;
        #1 `CHK(BUS_STATE, WSC_ST_T1);
        @(posedge CLK);
        SYSTEM_STOP <= stp;
        #1 `CHK(BUS_STATE, WSC_ST_T2);
        if (stp) begin
            repeat (4) begin
                @(posedge CLK);
                #1 `CHK(BUS_STATE, WSC_ST_T2);
            end
            @(posedge CLK);
            SYSTEM_STOP <= 1'b0;
            #1 `CHK(BUS_STATE, WSC_ST_T2);
        end
        for (int i = 0; i < 100; i++) begin
            @(posedge CLK);
            #1;
            if (BUS_STATE === WSC_ST_T3) break;
            `CHK(BUS_STATE, WSC_ST_TW);
            last_w++;
        end
        `CHK(BUS_STATE, WSC_ST_T3);
        `CHK(BUS_AREA, ar);
        if (n >= 0) `CHK(last_w, n);
        @(posedge CLK);
        #1 `CHK(BUS_STATE, WSC_ST_IDLE);
    endtask

    initial begin
        #200000;
        error_cnt++;
        test_done();
    end

    initial begin
        repeat (20) @(posedge CLK);
        RST_B <= 1'b1;
        rchk(WSC_OFS_LOWER_BND, 32'h0);
        rchk(WSC_OFS_UPPER_BND, 32'h0);
        rchk(WSC_OFS_LOW_WAIT, 32'h7);
        rchk(WSC_OFS_MID_WAIT, 32'h7);
        rchk(WSC_OFS_HIGH_WAIT, 32'h7);
        dma(24'h7f0000, WSC_AREA_LOW, 7, 1'b0);
        ahb(1'b1, 12'h018, 32'hff);
        rchk(12'h018, 32'h0);
        ahb(1'b1, WSC_OFS_LOWER_BND, 32'h01);
        ahb(1'b1, WSC_OFS_UPPER_BND, 32'h40);
        ahb(1'b1, WSC_OFS_LOW_WAIT, 32'h1);
        ahb(1'b1, WSC_OFS_MID_WAIT, 32'h03);
        ahb(1'b1, WSC_OFS_HIGH_WAIT, 32'h5);
        rchk(WSC_OFS_LOWER_BND, 32'h01);
        rchk(WSC_OFS_UPPER_BND, 32'h40);
        rchk(WSC_OFS_MID_WAIT, 32'h3);
        dma(24'h00ffff, WSC_AREA_LOW, 1, 1'b0);
        dma(24'h010000, WSC_AREA_MID, 3, 1'b0);
        dma(24'h3fffff, WSC_AREA_MID, 3, 1'b0);
        dma(24'h400000, WSC_AREA_HIGH, 5, 1'b0);
        dma(24'hffffff, WSC_AREA_HIGH, 5, 1'b0);
        ahb(1'b1, WSC_OFS_UPPER_BND, 32'h00);
        dma(24'hffffff, WSC_AREA_MID, 3, 1'b0);
        ahb(1'b1, WSC_OFS_LOWER_BND, 32'h00);
        dma(24'hffffff, WSC_AREA_LOW, 1, 1'b0);
        ahb(1'b1, WSC_OFS_LOW_WAIT, 32'h0);
        dma(24'h000000, WSC_AREA_LOW, 0, 1'b0);
        ahb(1'b1, WSC_OFS_LOW_WAIT, 32'h7);
        hold <= 4'h2;
        dma(24'h000000, WSC_AREA_LOW, 7, 1'b0);
        // pin raised a few clocks ahead so the synchronised level is seen in T2.
        hold <= 4'h6;
        ahb(1'b1, WSC_OFS_LOW_WAIT, 32'h1);
        dma(24'h000000, WSC_AREA_LOW, -1, 1'b0);
        `CHK(last_w >= 6, 1'b1);
        hold <= 4'h0;
        ahb(1'b1, WSC_OFS_LOW_WAIT, 32'h2);
        dma(24'h000000, WSC_AREA_LOW, 2, 1'b1);
        rchk(WSC_OFS_LOW_WAIT, 32'h2);
        rchk(WSC_OFS_STATUS, 32'(WSC_ST_IDLE) << WSC_STAT_STATE_LSB);
        test_done();
    end
endmodule
